/* hw/pll_seq_pkg.sv */
// constants, encodings and carrier types for the clock ratio change sequencer
package pll_seq_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // register addresses (byte addresses, one byte per register)
    localparam logic [31:0] ADDR_WDT_CSR  = 32'hFFFFFE80;
    localparam logic [31:0] ADDR_WDT_CNT  = 32'hFFFFFE81;
    localparam logic [31:0] ADDR_RST_WR   = 32'hFFFFFE82;
    localparam logic [31:0] ADDR_RST_RD   = 32'hFFFFFE83;
    localparam logic [31:0] ADDR_RATIO    = 32'hFFFFFE90;

    // write keys carried in the upper byte of a watchdog write
    localparam logic [7:0]  KEY_CSR       = 8'hA5;
    localparam logic [7:0]  KEY_CNT       = 8'h5A;
    localparam logic [7:0]  KEY_RST_FLAG  = 8'hA5;
    localparam logic [7:0]  KEY_RST_BITS  = 8'h5A;

    ////////////////////////////////////////////////////////////////////////////////
    // watchdog_control_status fields
    localparam int          CSR_OVF       = 7;
    localparam int          CSR_WTIT      = 6;
    localparam int          CSR_TME       = 5;
    localparam logic [1:0]  CSR_RSV_ONES  = 2'h3;
    // watchdog_reset_status fields
    localparam int          RST_WATCHDOG_OVERFLOW_FLAG      = 7;
    localparam int          RST_RSTE      = 6;
    localparam int          RST_RSTS      = 5;
    localparam logic [4:0]  RST_RSV_ONES  = 5'h1F;
    // clock_ratio_setting fields
    localparam int          RATIO_HALT2   = 7;
    localparam int          RATIO_HALT1   = 6;
    localparam int          RATIO_BUS_CLOCK_PIN    = 5;
    localparam int          RATIO_RSV     = 4;

    ////////////////////////////////////////////////////////////////////////////////
    // initial clock_ratio_setting per clock mode pin value
    localparam logic [7:0]  RATIO_INIT [8] = '{8'h00, 8'h00, 8'h40, 8'h60, 8'hA6, 8'hA6, 8'hE0, 8'hE0};
    // prescaler shift per watchdog_clock_select value, code 7 is divide by 16384
    localparam logic [3:0]  PRESCALE_SHIFT [8] = '{4'h1, 4'h2, 4'h4, 4'h6, 4'h8, 4'hA, 4'hC, 4'hE};
    localparam int          PRESCALE_W    = 14;
    // cycles after reset release until the synchronised mode pins are trusted
    localparam logic [1:0]  STRAP_SETTLE  = 2'h2;
    localparam logic [7:0]  COUNT_TOP     = 8'hFF;

    ////////////////////////////////////////////////////////////////////////////////
    typedef enum logic [1:0] {
        SEQ_IDLE   = 2'b00,
        SEQ_SETTLE = 2'b01,
        SEQ_RESUME = 2'b10
    } seq_state_t;

    typedef struct packed {
        logic [31:0] addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } reg_req_t;

    typedef struct packed {
        logic        clocks_run;
        logic        pll_one_halt;
        logic        pll_two_halt;
        logic        bus_clock_drive;
        logic [3:0]  ratio_field;
    } clock_ctrl_t;

endpackage

/* hw/watchdog_tick_counter.sv */
// prescaler and 8-bit up counter of the watchdog counter unit
`timescale 1ns/1ps
module watchdog_tick_counter (
    input  wire logic       clk_sys_i,
    input  wire logic       rst_i,
    input  wire logic       run_i,
    input  wire logic [2:0] clock_select_i,
    input  wire logic       load_i,
    input  wire logic [7:0] load_value_i,
    output logic      [7:0] count_o,
    output logic            overflow_o
);

    typedef struct packed {
        logic [pll_seq_pkg::PRESCALE_W-1:0] prescale;
        logic [7:0]                         count;
        logic                               overflow;
    } tick_state_t;

    tick_state_t                        st;
    tick_state_t                        next_st;
    logic [pll_seq_pkg::PRESCALE_W-1:0] mask;
    logic                               tick;

    always_comb begin
        next_st = st;
        mask = pll_seq_pkg::PRESCALE_W'((15'h0001 << pll_seq_pkg::PRESCALE_SHIFT[clock_select_i]) - 15'h0001);
        tick = run_i && ((st.prescale & mask) == mask);
        next_st.overflow = 1'b0;
        if (run_i) begin
            next_st.prescale = st.prescale + 14'h0001;
        end else begin
            next_st.prescale = '0;
        end
        if (load_i) begin
            next_st.count = load_value_i;
        end else if (tick) begin
            next_st.count = st.count + 8'h01;
            next_st.overflow = (st.count == pll_seq_pkg::COUNT_TOP);
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign count_o    = st.count;
    assign overflow_o = st.overflow;

endmodule

/* hw/pll_frequency_change_sequencer.sv */
// clock ratio register, watchdog registers and the frequency change sequencer
//
// Implementation choice: strobed register access.
`timescale 1ns/1ps
module pll_frequency_change_sequencer (
    input  wire logic                     clk_sys_i,
    input  wire logic                     rst_i,
    input  wire pll_seq_pkg::reg_req_t    reg_req_i,
    output logic                    [7:0] reg_rdata_o,
    input  wire logic               [2:0] clock_mode_pins_i,
    input  wire logic                     cache_through_read_i,
    input  wire logic                     external_write_i,
    output pll_seq_pkg::clock_ctrl_t      clock_ctrl_o,
    output logic                          bus_clock_stable_o,
    output logic                          change_busy_o,
    output logic                          interval_interrupt_o,
    output logic                          overflow_output_pin_o,
    output logic                          watchdog_reset_o
);

    ////////////////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        logic [2:0]               mode_meta;
        logic [2:0]               mode_sync;
        logic [1:0]               strap_cnt;
        logic                     strap_done;
        logic                     interval_overflow_flag;
        logic                     timer_mode_select;
        logic                     timer_run_enable;
        logic [2:0]               watchdog_clock_select;
        logic                     watchdog_overflow_flag;
        logic                     reset_enable;
        logic                     reset_select;
        logic [7:0]               clock_ratio_setting;
        logic                     prep_armed;
        pll_seq_pkg::seq_state_t  seq;
        logic                     busy;
        pll_seq_pkg::clock_ctrl_t clk;
        logic                     stable;
        logic [7:0]               rdata;
        logic                     interval_interrupt;
        logic                     ovf_pin;
        logic                     wdt_rst;
    } seq_top_state_t;

    seq_top_state_t st;
    seq_top_state_t next_st;
    logic [7:0]     count;
    logic           overflow;
    logic           count_run;
    logic           count_load;
    logic [7:0]     ratio_written;
    logic           prep_ok;
    logic           ratio_wr;

    ////////////////////////////////////////////////////////////////////////////////
    // forced bits of the ratio register per clock mode

    function automatic logic [7:0] force_bits(input logic [2:0] mode, input logic [7:0] value);
        logic [7:0] v;
        v = value;
        v[pll_seq_pkg::RATIO_RSV] = 1'b0;
        if (mode >= 3'h4) begin
            v[pll_seq_pkg::RATIO_HALT2] = 1'b1;
            v[pll_seq_pkg::RATIO_BUS_CLOCK_PIN] = 1'b1;
        end
        if (mode == 3'h2 || mode == 3'h3 || mode >= 3'h6) begin
            v[pll_seq_pkg::RATIO_HALT1] = 1'b1;
        end
        return v;
    endfunction

    function automatic pll_seq_pkg::clock_ctrl_t apply(input logic [7:0] value, input logic run);
        pll_seq_pkg::clock_ctrl_t c;
        c.clocks_run = run;
        c.pll_one_halt = value[pll_seq_pkg::RATIO_HALT1];
        c.pll_two_halt = value[pll_seq_pkg::RATIO_HALT2];
        c.bus_clock_drive = ~value[pll_seq_pkg::RATIO_BUS_CLOCK_PIN];
        c.ratio_field = value[3:0];
        return c;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // watchdog counter unit

    // the settle phase runs the counter even with the run enable clear
    assign count_run = st.timer_run_enable || (st.seq == pll_seq_pkg::SEQ_SETTLE);
    assign count_load = reg_req_i.wr && (reg_req_i.addr == pll_seq_pkg::ADDR_WDT_CNT)
                        && (reg_req_i.wdata[15:8] == pll_seq_pkg::KEY_CNT);

    watchdog_tick_counter u_counter (
        .clk_sys_i      (clk_sys_i),
        .rst_i          (rst_i),
        .run_i          (count_run),
        .clock_select_i (st.watchdog_clock_select),
        .load_i         (count_load),
        .load_value_i   (reg_req_i.wdata[7:0]),
        .count_o        (count),
        .overflow_o     (overflow)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        next_st = st;
        ratio_written = force_bits(st.mode_sync, reg_req_i.wdata[7:0]);
        prep_ok = st.prep_armed && !st.timer_run_enable && !st.timer_mode_select;
        ratio_wr = reg_req_i.wr && (reg_req_i.addr == pll_seq_pkg::ADDR_RATIO);
        next_st.interval_interrupt = 1'b0;
        next_st.ovf_pin = 1'b0;
        next_st.wdt_rst = 1'b0;
        next_st.rdata = 8'h00;

        // mode pins: two flops, then captured once after reset release
        next_st.mode_meta = clock_mode_pins_i;
        next_st.mode_sync = st.mode_meta;
        if (!st.strap_done) begin
            if (st.strap_cnt == pll_seq_pkg::STRAP_SETTLE) begin
                next_st.strap_done = 1'b1;
                next_st.clock_ratio_setting = force_bits(st.mode_sync,
                                                         pll_seq_pkg::RATIO_INIT[st.mode_sync]);
                next_st.clk = apply(force_bits(st.mode_sync, pll_seq_pkg::RATIO_INIT[st.mode_sync]), 1'b1);
                next_st.stable = 1'b1;
            end else begin
                next_st.strap_cnt = st.strap_cnt + 2'h1;
            end
        end

        // preparation tracking: a read arms, any external write disarms
        if (cache_through_read_i) begin
            next_st.prep_armed = 1'b1;
        end
        if (external_write_i) begin
            next_st.prep_armed = 1'b0;
        end

        // watchdog control and status writes
        if (reg_req_i.wr && reg_req_i.addr == pll_seq_pkg::ADDR_WDT_CSR
            && reg_req_i.wdata[15:8] == pll_seq_pkg::KEY_CSR) begin
            next_st.interval_overflow_flag = st.interval_overflow_flag & reg_req_i.wdata[pll_seq_pkg::CSR_OVF];
            next_st.timer_mode_select = reg_req_i.wdata[pll_seq_pkg::CSR_WTIT];
            next_st.timer_run_enable = reg_req_i.wdata[pll_seq_pkg::CSR_TME];
            next_st.watchdog_clock_select = reg_req_i.wdata[2:0];
        end
        if (reg_req_i.wr && reg_req_i.addr == pll_seq_pkg::ADDR_RST_WR) begin
            if (reg_req_i.wdata[15:8] == pll_seq_pkg::KEY_RST_FLAG && !reg_req_i.wdata[pll_seq_pkg::RST_WATCHDOG_OVERFLOW_FLAG]) begin
                next_st.watchdog_overflow_flag = 1'b0;
            end
            if (reg_req_i.wdata[15:8] == pll_seq_pkg::KEY_RST_BITS) begin
                next_st.reset_enable = reg_req_i.wdata[pll_seq_pkg::RST_RSTE];
                next_st.reset_select = reg_req_i.wdata[pll_seq_pkg::RST_RSTS];
            end
        end

        // overflow outside a frequency change; set wins over a clear
        if (overflow && st.seq != pll_seq_pkg::SEQ_SETTLE) begin
            if (st.timer_mode_select) begin
                next_st.watchdog_overflow_flag = 1'b1;
                next_st.ovf_pin = 1'b1;
                next_st.wdt_rst = st.reset_enable;
            end else begin
                next_st.interval_overflow_flag = 1'b1;
                next_st.interval_interrupt = 1'b1;
            end
        end

        // frequency change sequencer
        case (st.seq)
            pll_seq_pkg::SEQ_IDLE: begin
                if (ratio_wr && st.strap_done && prep_ok && ratio_written != st.clock_ratio_setting) begin
                    next_st.clock_ratio_setting = ratio_written;
                    next_st.prep_armed = 1'b0;
                    next_st.clk.clocks_run = 1'b0;
                    next_st.stable = 1'b0;
                    next_st.seq = pll_seq_pkg::SEQ_SETTLE;
                    next_st.busy = 1'b1;
                end
            end
            pll_seq_pkg::SEQ_SETTLE: begin
                if (overflow) begin
                    // no flag, interrupt or pin on this overflow
                    next_st.clk = apply(st.clock_ratio_setting, 1'b0);
                    next_st.seq = pll_seq_pkg::SEQ_RESUME;
                end
            end
            pll_seq_pkg::SEQ_RESUME: begin
                next_st.clk.clocks_run = 1'b1;
                next_st.stable = 1'b1;
                next_st.seq = pll_seq_pkg::SEQ_IDLE;
                next_st.busy = 1'b0;
            end
            default: begin
                next_st.seq = pll_seq_pkg::SEQ_IDLE;
                next_st.busy = 1'b0;
            end
        endcase

        // register reads, data valid in the following cycle only
        if (reg_req_i.rd) begin
            case (reg_req_i.addr)
                pll_seq_pkg::ADDR_WDT_CSR: begin
                    next_st.rdata = {st.interval_overflow_flag, st.timer_mode_select, st.timer_run_enable,
                                     pll_seq_pkg::CSR_RSV_ONES, st.watchdog_clock_select};
                end
                pll_seq_pkg::ADDR_WDT_CNT: begin
                    next_st.rdata = count;
                end
                pll_seq_pkg::ADDR_RST_RD: begin
                    next_st.rdata = {st.watchdog_overflow_flag, st.reset_enable, st.reset_select,
                                     pll_seq_pkg::RST_RSV_ONES};
                end
                pll_seq_pkg::ADDR_RATIO: begin
                    next_st.rdata = st.clock_ratio_setting;
                end
                default: begin
                    next_st.rdata = 8'h00;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // registers; rst_i is the power-on reset, watchdog resets never reach here

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // outputs

    assign reg_rdata_o           = st.rdata;
    assign clock_ctrl_o          = st.clk;
    assign bus_clock_stable_o    = st.stable;
    assign change_busy_o         = st.busy;
    assign interval_interrupt_o  = st.interval_interrupt;
    assign overflow_output_pin_o = st.ovf_pin;
    assign watchdog_reset_o      = st.wdt_rst;

endmodule

/* bench/pll_frequency_change_sequencer_chk.sv */
// port assertions for the clock ratio change sequencer
`timescale 1ns/1ps
module pll_frequency_change_sequencer_chk (
    input  wire logic                     clk_sys_i,
    input  wire logic                     rst_i,
    input  wire pll_seq_pkg::reg_req_t    reg_req_i,
    input  wire logic               [7:0] reg_rdata_o,
    input  wire logic               [2:0] clock_mode_pins_i,
    input  wire logic                     cache_through_read_i,
    input  wire logic                     external_write_i,
    input  wire pll_seq_pkg::clock_ctrl_t clock_ctrl_o,
    input  wire logic                     bus_clock_stable_o,
    input  wire logic                     change_busy_o,
    input  wire logic                     interval_interrupt_o,
    input  wire logic                     overflow_output_pin_o,
    input  wire logic                     watchdog_reset_o
);
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (rst_i);

    sequence ratio_write;
        reg_req_i.wr && reg_req_i.addr == pll_seq_pkg::ADDR_RATIO && !cache_through_read_i;
    endsequence
    // arming cancelled two cycles before the ratio write, no re-arming between
    sequence disarmed_write;
        (external_write_i && !change_busy_o && !reg_req_i.wr) ##1 !cache_through_read_i ##1 ratio_write;
    endsequence

    a_rdata_idle: assert property (!$past(reg_req_i.rd) |-> reg_rdata_o == 8'h00)
        else $error("read data not zero outside read answer");
    a_gate_on_start: assert property ($rose(change_busy_o) |->
        !clock_ctrl_o.clocks_run && !bus_clock_stable_o) else $error("clocks not stopped when change began");
    a_start_by_write: assert property ($rose(change_busy_o) |-> $past(reg_req_i.wr) &&
        $past(reg_req_i.addr) == pll_seq_pkg::ADDR_RATIO) else $error("change began without ratio write");
    a_gated_throughout: assert property (change_busy_o |-> !clock_ctrl_o.clocks_run)
        else $error("clocks running during change");
    a_quiet_change: assert property (change_busy_o |->
        !(interval_interrupt_o || overflow_output_pin_o || watchdog_reset_o)) else $error("overflow signalled in change");
    a_unstable_busy: assert property (change_busy_o |-> !bus_clock_stable_o)
        else $error("bus clock flagged stable while settling");
    a_resume_run: assert property ($fell(change_busy_o) |-> clock_ctrl_o.clocks_run && bus_clock_stable_o)
        else $error("clocks not resumed at end of change");
    a_refused_prep: assert property (disarmed_write |=> !change_busy_o)
        else $error("unprepared ratio write started a change");
    a_switch_gated: assert property ($changed(clock_ctrl_o.ratio_field) && $past(change_busy_o)
        |-> !clock_ctrl_o.clocks_run) else $error("ratio switched with clocks running");
endmodule

bind pll_frequency_change_sequencer pll_frequency_change_sequencer_chk u_chk (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .reg_req_i(reg_req_i), .reg_rdata_o(reg_rdata_o),
    .clock_mode_pins_i(clock_mode_pins_i), .cache_through_read_i(cache_through_read_i),
    .external_write_i(external_write_i), .clock_ctrl_o(clock_ctrl_o), .bus_clock_stable_o(bus_clock_stable_o),
    .change_busy_o(change_busy_o), .interval_interrupt_o(interval_interrupt_o),
    .overflow_output_pin_o(overflow_output_pin_o), .watchdog_reset_o(watchdog_reset_o)
);

/* bench/pll_frequency_change_sequencer_tb.sv */
// self-checking bench for the clock ratio change sequencer
`timescale 1ns/1ps
module pll_frequency_change_sequencer_tb;
    logic                     clk_sys_i            = 1'b0;
    logic                     rst_i                = 1'b1;
    pll_seq_pkg::reg_req_t    reg_req_i            = '0;
    logic               [2:0] clock_mode_pins_i    = 3'h0;
    logic                     cache_through_read_i = 1'b0;
    logic                     external_write_i     = 1'b0;
    logic               [7:0] reg_rdata_o;
    pll_seq_pkg::clock_ctrl_t clock_ctrl_o;
    logic                     bus_clock_stable_o;
    logic                     change_busy_o;
    logic                     interval_interrupt_o;
    logic                     overflow_output_pin_o;
    logic                     watchdog_reset_o;
    int                       miscompares          = 0;
    int                       num_checks           = 0;
    int                       stray_pulses         = 0;
    int                       iti_pulses           = 0;
    logic               [7:0] rd_val;
    logic               [7:0] first_cnt;

    always #12.5 clk_sys_i = ~clk_sys_i; // driven clock input, no crystal on the oscillator

    pll_frequency_change_sequencer DUT (
        .clk_sys_i(clk_sys_i), .rst_i(rst_i), .reg_req_i(reg_req_i), .reg_rdata_o(reg_rdata_o),
        .clock_mode_pins_i(clock_mode_pins_i), .cache_through_read_i(cache_through_read_i),
        .external_write_i(external_write_i), .clock_ctrl_o(clock_ctrl_o), .bus_clock_stable_o(bus_clock_stable_o),
        .change_busy_o(change_busy_o), .interval_interrupt_o(interval_interrupt_o),
        .overflow_output_pin_o(overflow_output_pin_o), .watchdog_reset_o(watchdog_reset_o)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // overflow signals must stay quiet while a change is running
    always @(posedge clk_sys_i) begin
        if (change_busy_o === 1'b1 && (interval_interrupt_o | overflow_output_pin_o | watchdog_reset_o) !== 1'b0) begin
            stray_pulses++;
        end
        if (interval_interrupt_o === 1'b1) begin
            iti_pulses++;
        end
    end

    task automatic wrap_up();
        if (miscompares == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] expected);
        num_checks++;
        if (seen !== expected) begin
            miscompares++;
            $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, expected);
        end
    endtask

    task automatic reg_write(input logic [31:0] addr, input logic [15:0] wdata);
        @(posedge clk_sys_i);
        reg_req_i <= '{addr: addr, wdata: wdata, wr: 1'b1, rd: 1'b0};
        @(posedge clk_sys_i);
        reg_req_i.wr <= 1'b0;
        #1;
    endtask

    task automatic reg_read(input logic [31:0] addr, output logic [7:0] data);
        @(posedge clk_sys_i);
        reg_req_i <= '{addr: addr, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge clk_sys_i);
        reg_req_i.rd <= 1'b0;
        #1;
        data = reg_rdata_o;
    endtask

    // one-cycle pulse on the cache-through read line or the external write line
    task automatic pulse_line(input bit ext);
        @(posedge clk_sys_i);
        if (ext) begin
            external_write_i <= 1'b1;
        end else begin
            cache_through_read_i <= 1'b1;
        end
        @(posedge clk_sys_i);
        external_write_i     <= 1'b0;
        cache_through_read_i <= 1'b0;
    endtask

    task automatic do_reset(input logic [2:0] mode);
        rst_i             <= 1'b1;
        clock_mode_pins_i <= mode;
        repeat (2) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        repeat (6) @(posedge clk_sys_i);
        #1;
    endtask

    task automatic wait_idle();
        for (int i = 0; i < 200 && change_busy_o !== 1'b0; i++) begin
            @(posedge clk_sys_i);
            #1;
        end
        check(change_busy_o, 1'b0);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #500000;
        miscompares++;
        wrap_up();
    end

    initial begin
        do_reset(3'h0);
        reg_read(pll_seq_pkg::ADDR_RATIO, rd_val);
        check(rd_val, 8'h00);
        check(clock_ctrl_o.clocks_run, 1'b1);
        reg_read(32'hFFFFFE84, rd_val);
        check(rd_val, 8'h00);
        reg_write(pll_seq_pkg::ADDR_RATIO, 16'h0008);
        check(change_busy_o, 1'b0);
        reg_write(pll_seq_pkg::ADDR_WDT_CSR, {pll_seq_pkg::KEY_CSR, 8'h1F});
        reg_read(pll_seq_pkg::ADDR_WDT_CSR, rd_val);
        check(rd_val, 8'h1F);
        reg_write(pll_seq_pkg::ADDR_WDT_CSR, {pll_seq_pkg::KEY_CSR, 8'h00});
        reg_write(pll_seq_pkg::ADDR_WDT_CNT, {pll_seq_pkg::KEY_CNT, 8'hF0});
        reg_read(pll_seq_pkg::ADDR_WDT_CNT, rd_val);
        check(rd_val, 8'hF0);
        // arming cancelled by an external write
        pulse_line(1'b0);
        pulse_line(1'b1);
        reg_write(pll_seq_pkg::ADDR_RATIO, 16'h0008);
        check(change_busy_o, 1'b0);
        reg_read(pll_seq_pkg::ADDR_WDT_CNT, rd_val);
        check(rd_val, 8'hF0);
        // accepted change, count prescaled by two
        pulse_line(1'b0);
        reg_write(pll_seq_pkg::ADDR_RATIO, 16'h0008);
        check({change_busy_o, clock_ctrl_o.clocks_run, bus_clock_stable_o}, 3'b100);
        reg_read(pll_seq_pkg::ADDR_WDT_CNT, first_cnt);
        reg_read(pll_seq_pkg::ADDR_WDT_CNT, rd_val);
        check(first_cnt, 8'hF0);
        check(rd_val, 8'hF1);
        wait_idle();
        check(clock_ctrl_o, {1'b1, 1'b0, 1'b0, 1'b1, 4'h8});
        check(bus_clock_stable_o, 1'b1);
        check(stray_pulses, 0);
        reg_read(pll_seq_pkg::ADDR_WDT_CSR, rd_val);
        check(rd_val, 8'h18);
        reg_read(pll_seq_pkg::ADDR_RST_RD, rd_val);
        check(rd_val, 8'h1F);
        // same value again, then run enable set: both refused
        pulse_line(1'b0);
        reg_write(pll_seq_pkg::ADDR_RATIO, 16'h0008);
        check(change_busy_o, 1'b0);
        reg_write(pll_seq_pkg::ADDR_WDT_CSR, {pll_seq_pkg::KEY_CSR, 8'h20});
        pulse_line(1'b0);
        reg_write(pll_seq_pkg::ADDR_RATIO, 16'h000A);
        check(change_busy_o, 1'b0);
        // interval overflow outside a change sets the flag and pulses the interrupt
        reg_write(pll_seq_pkg::ADDR_WDT_CNT, {pll_seq_pkg::KEY_CNT, 8'hFE});
        repeat (8) @(posedge clk_sys_i);
        reg_read(pll_seq_pkg::ADDR_WDT_CSR, rd_val);
        check(rd_val, 8'hB8);
        check(iti_pulses, 1);
        reg_write(pll_seq_pkg::ADDR_WDT_CSR, {pll_seq_pkg::KEY_CSR, 8'h00});
        reg_read(pll_seq_pkg::ADDR_WDT_CSR, rd_val);
        check(rd_val, 8'h18);
        reg_read(pll_seq_pkg::ADDR_RATIO, rd_val);
        check(rd_val, 8'h08);
        do_reset(3'h4);
        reg_read(pll_seq_pkg::ADDR_RATIO, rd_val);
        check(rd_val, 8'hA6);
        // mode 4 change: pll two halt and bus clock bits stay forced
        reg_write(pll_seq_pkg::ADDR_WDT_CNT, {pll_seq_pkg::KEY_CNT, 8'hFE});
        pulse_line(1'b0);
        reg_write(pll_seq_pkg::ADDR_RATIO, 16'h0005);
        wait_idle();
        check(clock_ctrl_o, {1'b1, 1'b0, 1'b1, 1'b0, 4'h5});
        reg_read(pll_seq_pkg::ADDR_RATIO, rd_val);
        check(rd_val, 8'hA5);
        wrap_up();
    end
endmodule
